//--- src/ccr_cfg.svh
// offsets, field positions, reset values and memory map limits of the core register block
`ifndef CCR_CFG_SVH
`define CCR_CFG_SVH

`define CCR_OFF_INSTR_POINTER 8'h00
`define CCR_OFF_WORK_ONE 8'h04
`define CCR_OFF_SECOND_OP 8'h08
`define CCR_OFF_INDEX 8'h0C
`define CCR_OFF_MEM_POINTER 8'h10
`define CCR_OFF_STACK_TOP 8'h14
`define CCR_OFF_STATUS_WORD 8'h18
`define CCR_OFF_OPERATION 8'h1C
`define CCR_OFF_PROBE 8'h20
`define CCR_OFF_PROBE_RESULT 8'h24

`define CCR_RESET_WORD 16'h0000
`define CCR_RESET_STATUS 16'h0000
`define CCR_RESET_OP 4'h0

`define CCR_BIT_NIBBLE_CARRY 7
`define CCR_BIT_GLOBAL_ENABLE 6
`define CCR_BIT_PRIO_HI 5
`define CCR_BIT_PRIO_LO 4
`define CCR_BIT_MSB_COPY 3
`define CCR_BIT_NIL_RESULT 2
`define CCR_BIT_SIGNED_SPILL 1
`define CCR_BIT_BIT7_SPILL_OUT 0

`define CCR_IO_TOP 16'h0080
`define CCR_DATA_TOP 16'h8000
`define CCR_GPR_BASE 16'h0100

`define CCR_RESP_OKAY 2'b00
`define CCR_RESP_SLVERR 2'b10

`endif

//--- src/ccr_pkg.sv
// types shared by the core register block
package ccr_pkg;
    typedef enum logic [3:0] {
        CCR_OP_ADD = 4'h0,
        CCR_OP_ADDC = 4'h1,
        CCR_OP_SUB = 4'h2,
        CCR_OP_SUBC = 4'h3,
        CCR_OP_CMP = 4'h4,
        CCR_OP_ROLC = 4'h5,
        CCR_OP_RORC = 4'h6,
        CCR_OP_MOV = 4'h7,
        CCR_OP_ADDW = 4'h8,
        CCR_OP_SUBW = 4'h9
    } ccr_op_t;

    typedef enum logic [1:0] {
        CCR_REGION_IO = 2'h0,
        CCR_REGION_DATA = 2'h1,
        CCR_REGION_PROGRAM = 2'h2
    } ccr_region_t;
endpackage

//--- src/ccr_core_regs.sv
// cpu core dedicated registers, condition flags and bank addressing behind an axi4-lite slave
//
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
`include "ccr_cfg.svh"

module ccr_core_regs
    import ccr_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write address channel
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // write data channel
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // write response channel
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read address channel
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // read data channel
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // interrupt request and acceptance
    input wire logic irq_request,
    input wire logic [1:0] irq_level,
    output logic irq_accept
);

    // dedicated registers
    logic [15:0] instr_pointer;
    logic [15:0] work_register_one;
    logic [15:0] second_operand_reg;
    logic [15:0] index_reg;
    logic [15:0] mem_pointer;
    logic [15:0] stack_top;
    logic [15:0] status_word;
    logic [3:0] last_op;
    logic [15:0] probe_addr;
    logic [2:0] probe_regnum;

    // bus slave state
    logic aw_held;
    logic w_held;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;

    wire [7:0] bank_select = status_word[15:8];
    wire [7:0] flag_byte = status_word[7:0];
    wire global_enable = flag_byte[`CCR_BIT_GLOBAL_ENABLE];
    wire [1:0] prio_threshold = flag_byte[`CCR_BIT_PRIO_HI:`CCR_BIT_PRIO_LO];
    wire carry_in = flag_byte[`CCR_BIT_BIT7_SPILL_OUT];

    // lower number is higher priority, so level all-ones can never outrank the threshold
    assign irq_accept = irq_request && global_enable && (irq_level < prio_threshold);

    // memory map probe
    ccr_region_t probe_region;
    assign probe_region = (probe_addr < `CCR_IO_TOP) ? CCR_REGION_IO :
                          (probe_addr < `CCR_DATA_TOP) ? CCR_REGION_DATA : CCR_REGION_PROGRAM;
    // only the low four pointer bits select among the 16 banks
    wire [15:0] gpr_addr = `CCR_GPR_BASE + {9'h000, bank_select[3:0], probe_regnum};

    // arithmetic unit, one operation per write to the operation register with byte lane 0 strobed
    logic [15:0] alu_result;
    logic [7:0] next_flags;
    logic alu_writes;
    logic alu_sub;
    logic alu_wide;
    logic [15:0] opnd_b;
    logic [16:0] sum;
    logic cin_eff;
    logic [3:0] op_code;

    assign op_code = wr_data[3:0];

    always_comb
    begin
        alu_sub = (op_code == CCR_OP_SUB) || (op_code == CCR_OP_SUBC) ||
                  (op_code == CCR_OP_CMP) || (op_code == CCR_OP_SUBW);
        alu_wide = (op_code == CCR_OP_ADDW) || (op_code == CCR_OP_SUBW);
        // subtraction as addition of the complement; carry in inverted to borrow
        opnd_b = alu_sub ? ~second_operand_reg : second_operand_reg;
        case (op_code)
            CCR_OP_ADDC: cin_eff = carry_in;
            CCR_OP_SUBC: cin_eff = ~carry_in;
            CCR_OP_SUB, CCR_OP_CMP, CCR_OP_SUBW: cin_eff = 1'b1;
            default: cin_eff = 1'b0;
        endcase
        if (alu_wide)
            sum = {1'b0, work_register_one} + {1'b0, opnd_b} + {16'h0000, cin_eff};
        else
            sum = {8'h00, 1'b0, work_register_one[7:0]} + {8'h00, 1'b0, opnd_b[7:0]} + {16'h0000, cin_eff};
        next_flags = flag_byte;
        alu_result = work_register_one;
        alu_writes = 1'b1;
        case (op_code)
            CCR_OP_ADD, CCR_OP_ADDC, CCR_OP_SUB, CCR_OP_SUBC, CCR_OP_CMP:
            begin
                alu_result = {work_register_one[15:8], sum[7:0]};
                alu_writes = (op_code != CCR_OP_CMP);
                next_flags[`CCR_BIT_NIBBLE_CARRY] =
                    work_register_one[4] ^ second_operand_reg[4] ^ sum[4];
                next_flags[`CCR_BIT_MSB_COPY] = sum[7];
                next_flags[`CCR_BIT_NIL_RESULT] = (sum[7:0] == 8'h00);
                next_flags[`CCR_BIT_SIGNED_SPILL] =
                    (work_register_one[7] == opnd_b[7]) && (sum[7] != work_register_one[7]);
                next_flags[`CCR_BIT_BIT7_SPILL_OUT] = alu_sub ? ~sum[8] : sum[8];
            end
            CCR_OP_ADDW, CCR_OP_SUBW:
            begin
                alu_result = sum[15:0];
                next_flags[`CCR_BIT_MSB_COPY] = sum[15];
                next_flags[`CCR_BIT_NIL_RESULT] = (sum[15:0] == 16'h0000);
                next_flags[`CCR_BIT_SIGNED_SPILL] =
                    (work_register_one[15] == opnd_b[15]) && (sum[15] != work_register_one[15]);
                next_flags[`CCR_BIT_BIT7_SPILL_OUT] = alu_sub ? ~sum[16] : sum[16];
            end
            CCR_OP_ROLC, CCR_OP_RORC:
            begin
                if (op_code == CCR_OP_ROLC)
                begin
                    alu_result = {work_register_one[15:8], work_register_one[6:0], carry_in};
                    next_flags[`CCR_BIT_BIT7_SPILL_OUT] = work_register_one[7];
                end
                else
                begin
                    alu_result = {work_register_one[15:8], carry_in, work_register_one[7:1]};
                    next_flags[`CCR_BIT_BIT7_SPILL_OUT] = work_register_one[0];
                end
                next_flags[`CCR_BIT_MSB_COPY] = alu_result[7];
                next_flags[`CCR_BIT_NIL_RESULT] = (alu_result[7:0] == 8'h00);
            end
            CCR_OP_MOV:
            begin
                // transfers report sign and zero of the moved byte only
                alu_result = {work_register_one[15:8], second_operand_reg[7:0]};
                next_flags[`CCR_BIT_MSB_COPY] = second_operand_reg[7];
                next_flags[`CCR_BIT_NIL_RESULT] = (second_operand_reg[7:0] == 8'h00);
            end
            default:
                alu_writes = 1'b0;
        endcase
    end

    // write path
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire do_write = aw_held && w_held && !s_axi_bvalid;
    wire wr_mapped = (wr_addr[1:0] == 2'b00) && (wr_addr <= `CCR_OFF_PROBE);
    wire wr_ip = do_write && (wr_addr == `CCR_OFF_INSTR_POINTER);
    wire wr_a = do_write && (wr_addr == `CCR_OFF_WORK_ONE);
    wire wr_t = do_write && (wr_addr == `CCR_OFF_SECOND_OP);
    wire wr_ix = do_write && (wr_addr == `CCR_OFF_INDEX);
    wire wr_ep = do_write && (wr_addr == `CCR_OFF_MEM_POINTER);
    wire wr_sp = do_write && (wr_addr == `CCR_OFF_STACK_TOP);
    wire wr_ps = do_write && (wr_addr == `CCR_OFF_STATUS_WORD);
    wire wr_op = do_write && (wr_addr == `CCR_OFF_OPERATION) && wr_strb[0];
    wire wr_probe = do_write && (wr_addr == `CCR_OFF_PROBE);
    wire [15:0] wmask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] data,
                                            input logic [15:0] mask);
        merge16 = (old & ~mask) | (data & mask);
    endfunction

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 32'h0000_0000;
            wr_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CCR_RESP_OKAY;
        end
        else
        begin
            if (aw_take)
            begin
                aw_held <= 1'b1;
                wr_addr <= s_axi_awaddr;
            end
            if (w_take)
            begin
                w_held <= 1'b1;
                wr_data <= s_axi_wdata;
                wr_strb <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_mapped ? `CCR_RESP_OKAY : `CCR_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // register file
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            instr_pointer <= `CCR_RESET_WORD;
            work_register_one <= `CCR_RESET_WORD;
            second_operand_reg <= `CCR_RESET_WORD;
            index_reg <= `CCR_RESET_WORD;
            mem_pointer <= `CCR_RESET_WORD;
            stack_top <= `CCR_RESET_WORD;
            status_word <= `CCR_RESET_STATUS;
            last_op <= `CCR_RESET_OP;
            probe_addr <= `CCR_RESET_WORD;
            probe_regnum <= 3'h0;
        end
        else
        begin
            if (wr_ip)
                instr_pointer <= merge16(instr_pointer, wr_data[15:0], wmask);
            if (wr_a)
                work_register_one <= merge16(work_register_one, wr_data[15:0], wmask);
            else if (wr_op && alu_writes)
                work_register_one <= alu_result;
            if (wr_t)
                second_operand_reg <= merge16(second_operand_reg, wr_data[15:0], wmask);
            if (wr_ix)
                index_reg <= merge16(index_reg, wr_data[15:0], wmask);
            if (wr_ep)
                mem_pointer <= merge16(mem_pointer, wr_data[15:0], wmask);
            if (wr_sp)
                stack_top <= merge16(stack_top, wr_data[15:0], wmask);
            if (wr_ps)
                status_word <= merge16(status_word, wr_data[15:0], wmask);
            else if (wr_op)
                status_word <= {status_word[15:8], next_flags};
            if (wr_op)
                last_op <= op_code;
            if (wr_probe && wr_strb[0])
                probe_addr[7:0] <= wr_data[7:0];
            if (wr_probe && wr_strb[1])
                probe_addr[15:8] <= wr_data[15:8];
            if (wr_probe && wr_strb[2])
                probe_regnum <= wr_data[18:16];
        end
    end

    // read path
    logic [31:0] rd_mux;
    logic rd_hit;

    always_comb
    begin
        rd_hit = 1'b1;
        case (s_axi_araddr)
            `CCR_OFF_INSTR_POINTER: rd_mux = {16'h0000, instr_pointer};
            `CCR_OFF_WORK_ONE: rd_mux = {16'h0000, work_register_one};
            `CCR_OFF_SECOND_OP: rd_mux = {16'h0000, second_operand_reg};
            `CCR_OFF_INDEX: rd_mux = {16'h0000, index_reg};
            `CCR_OFF_MEM_POINTER: rd_mux = {16'h0000, mem_pointer};
            `CCR_OFF_STACK_TOP: rd_mux = {16'h0000, stack_top};
            `CCR_OFF_STATUS_WORD: rd_mux = {16'h0000, status_word};
            `CCR_OFF_OPERATION: rd_mux = {28'h000_0000, last_op};
            `CCR_OFF_PROBE: rd_mux = {13'h0000, probe_regnum, probe_addr};
            `CCR_OFF_PROBE_RESULT: rd_mux = {14'h0000, probe_region, gpr_addr};
            default:
            begin
                rd_mux = 32'h0000_0000;
                rd_hit = 1'b0;
            end
        endcase
    end

    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `CCR_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_hit ? `CCR_RESP_OKAY : `CCR_RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

endmodule

//--- dv/ccr_core_regs_checker.sv
// concurrent checks on the core register block ports
module ccr_core_regs_checker (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    // interrupt gate
    input wire logic irq_request,
    input wire logic [1:0] irq_level,
    input wire logic irq_accept
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence aw_take;
        s_axi_awvalid && s_axi_awready;
    endsequence
    sequence w_take;
        s_axi_wvalid && s_axi_wready;
    endsequence
    sequence ar_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    AST_IRQ_NOREQ: assert property (!irq_request |-> !irq_accept)
        else $error("accept without request");
    AST_IRQ_LOWEST: assert property (irq_level == 2'h3 |-> !irq_accept)
        else $error("lowest level accepted");
    AST_IRQ_RESET: assert property (disable iff (1'b0) !aresetn ##1 aresetn |-> !irq_accept)
        else $error("accept right after reset");
    // both halves taken at one edge: the commit takes one more edge before the answer shows
    AST_WR_RESP: assert property (aw_take and w_take |=> ##1 s_axi_bvalid)
        else $error("write answer late");
    AST_RD_RESP: assert property (ar_take |=> s_axi_rvalid)
        else $error("read answer late");
    AST_B_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken under response");
    AST_R_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken under response");
    AST_WIDTH: assert property (ar_take ##0 s_axi_araddr < 8'h1C && s_axi_araddr[1:0] == 2'h0
        |=> s_axi_rdata[31:16] == 16'h0000) else $error("upper half not zero");
    AST_REGION: assert property (ar_take ##0 s_axi_araddr == 8'h24 |=> s_axi_rdata[31:18] == 14'h0000
        && s_axi_rdata[17:16] != 2'h3) else $error("bad region code");
    AST_GPR: assert property (ar_take ##0 s_axi_araddr == 8'h24 |=> s_axi_rdata[15:7] == 9'h002)
        else $error("bank address out of range");
endmodule

//--- dv/tb_cpu_core_registers_flags.sv
// self-checking bench for the core register block
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_errors++; $display("Error %0t: got %h exp %h", $time, g, e); end end
module tb_cpu_core_registers_flags import ccr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_accept;
    logic [1:0] s_axi_bresp, s_axi_rresp, irq_level = 2'h0;
    logic irq_request = 1'b0;
    logic [15:0] seed = 16'h934C;
    logic [15:0] lim [5] = '{16'h007F, 16'h0080, 16'h7FFF, 16'h8000, 16'hFFFF};
    int n_errors = 0, check_count = 0;
    always #2.5 aclk = ~aclk;
    ccr_core_regs DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .irq_request, .irq_level, .irq_accept);
    function automatic logic [15:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed;
    endfunction
    task automatic complete_run();
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic hang();
        n_errors++;
        $display("Error %0t: timeout", $time);
        complete_run();
    endtask
    // address and data released separately, each once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ta, tw, tb;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int n = 0; n < 20; n++)
        begin
            @(negedge aclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid;
            if (tb)
                `CHK(s_axi_bresp, er)
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (tb)
            begin
                s_axi_bready <= 1'b0;
                return;
            end
        end
        hang();
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        logic ta, tr;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int n = 0; n < 20; n++)
        begin
            @(negedge aclk);
            ta = s_axi_arvalid && s_axi_arready;
            tr = s_axi_rvalid;
            if (tr)
            begin
                `CHK(s_axi_rdata, e)
                `CHK(s_axi_rresp, er)
            end
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'b0;
            if (tr)
            begin
                s_axi_rready <= 1'b0;
                return;
            end
        end
        hang();
    endtask
    // reference arithmetic on plain integers
    task automatic model(input int op, input logic [15:0] t, inout logic [15:0] a, inout logic [7:0] f);
        int x, y, c, r, m, s;
        bit w;
        w = op > 7;
        m = w ? 65535 : 255;
        s = w ? 32768 : 128;
        x = w ? a : a[7:0];
        y = w ? t : t[7:0];
        c = (op == 1 || op == 3) ? f[0] : 0;
        if (op == 0 || op == 1 || op == 8)
        begin
            r = x + y + c;
            f[0] = r > m;
            f[1] = ((x ^ r) & (y ^ r) & s) != 0;
            if (!w) f[7] = (x % 16 + y % 16 + c) > 15;
        end
        else if (op < 5 || op == 9)
        begin
            r = x - y - c;
            f[0] = r < 0;
            f[1] = ((x ^ y) & (x ^ r) & s) != 0;
            if (!w) f[7] = (x % 16 - y % 16 - c) < 0;
        end
        else if (op == 5)
        begin
            r = (x << 1) | f[0];
            f[0] = x[7];
        end
        else if (op == 6)
        begin
            r = (x >> 1) | (f[0] << 7);
            f[0] = x[0];
        end
        else
            r = y;
        r = r & m;
        f[3] = (r & s) != 0;
        f[2] = r == 0;
        if (op == 4) return;
        if (w) a = r[15:0];
        else a[7:0] = r[7:0];
    endtask
    initial
    begin
        logic [15:0] a, t, p;
        logic [7:0] f, b;
        logic [1:0] g;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 7; i++)
            rc(8'(i * 4), 32'h0, 2'h0);
        for (int i = 0; i < 6; i++)
        begin
            p = rnd();
            wr(8'(i * 4), {rnd(), p}, 2'h0);
            rc(8'(i * 4), {16'h0000, p}, 2'h0);
        end
        // upper lane only: the low byte of stack_top must survive
        s_axi_wstrb <= 4'h2;
        wr(8'h14, 32'h0000_0000, 2'h0);
        rc(8'h14, {24'h000000, p[7:0]}, 2'h0);
        s_axi_wstrb <= 4'hF;
        wr(8'h28, 32'h1, 2'h2);
        rc(8'h28, 32'h0, 2'h2);
        wr(8'h24, 32'h1, 2'h2);
        wr(8'h18, 32'h0000A55A, 2'h0);
        rc(8'h18, 32'h0000A55A, 2'h0);
        for (int i = 0; i < 60; i++)
        begin
            a = rnd();
            t = rnd();
            b = 8'(rnd());
            f = 8'(rnd());
            if (i % 4 == 1) t = a;
            if (i % 4 == 2) t = ~a + 16'h0001;
            wr(8'h04, {16'h0000, a}, 2'h0);
            wr(8'h08, {16'h0000, t}, 2'h0);
            wr(8'h18, {16'h0000, b, f}, 2'h0);
            wr(8'h1C, 32'(i % 10), 2'h0);
            model(i % 10, t, a, f);
            rc(8'h04, {16'h0000, a}, 2'h0);
            rc(8'h18, {16'h0000, b, f}, 2'h0);
        end
        // an undefined code leaves the accumulator and flags alone
        wr(8'h1C, 32'h0000_000F, 2'h0);
        rc(8'h04, {16'h0000, a}, 2'h0);
        rc(8'h18, {16'h0000, b, f}, 2'h0);
        rc(8'h1C, 32'h0000_000F, 2'h0);
        for (int k = 0; k < 8; k++)
        begin
            wr(8'h18, {24'h000000, 1'b0, k[2], k[1:0], 4'h0}, 2'h0);
            for (int i = 0; i < 8; i++)
            begin
                @(posedge aclk);
                irq_request <= i[2];
                irq_level <= i[1:0];
                @(negedge aclk);
                `CHK(irq_accept, i[2] & k[2] & (i[1:0] < k[1:0]))
            end
        end
        // mid-run reset with the gate open must close it again
        wr(8'h18, 32'h0000_0070, 2'h0);
        @(posedge aclk);
        irq_request <= 1'b1;
        irq_level <= 2'h0;
        @(negedge aclk);
        `CHK(irq_accept, 1'b1)
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        `CHK(irq_accept, 1'b0)
        rc(8'h18, 32'h0, 2'h0);
        for (int i = 0; i < 12; i++)
        begin
            p = (i < 5) ? lim[i] : rnd();
            b = 8'(rnd());
            g = (p < 16'h0080) ? 2'h0 : (p < 16'h8000) ? 2'h1 : 2'h2;
            a = 16'h0100 + 16'(b[3:0]) * 16'h0008 + 16'(i % 8);
            wr(8'h18, {16'h0000, b, 8'h00}, 2'h0);
            wr(8'h20, {13'h0000, 3'(i % 8), p}, 2'h0);
            rc(8'h24, {14'h0000, g, a}, 2'h0);
        end
        complete_run();
    end
endmodule
bind ccr_core_regs ccr_core_regs_checker CHKR (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .irq_request, .irq_level, .irq_accept);
